// [design/tx_pll_oc_defs.svh]
// Purpose: Offsets, field positions, reset values and counts for the PLL select / offset cancel block
// Assumes: Avalon-MM byte addresses, one 32-bit word per register
// Notes: Definitions only
`ifndef TX_PLL_OC_DEFS_SVH
`define TX_PLL_OC_DEFS_SVH

`define REG_CTRL 8'h00
`define REG_IMG_LEN 8'h04
`define REG_REFCLK_ID 8'h08
`define REG_STATUS 8'h0c
`define REG_OC_DONE 8'h10

`define CTRL_GO_BIT 0
`define CTRL_ERR_CLR_BIT 1

`define ST_BUSY_BIT 0
`define ST_OC_DONE_BIT 1
`define ST_IMG_BUSY_BIT 2
`define ST_REFCLK_ERR_BIT 3
`define ST_PLL_IDX_BIT 4
`define ST_OVR_USED_BIT 5

`define IMG_LEN_RST 6'h3b
`define REFCLK_ID_RST 4'h1
`define REFCLK_ID_MIN 4'h1
`define REFCLK_ID_MAX 4'ha

`define PLL_IDX_WORD 6'h02
`define PLL_IDX_BIT 0

`endif

// [design/tx_pll_oc_pkg.sv]
// Purpose: Types shared by the PLL select / offset cancel design
// Assumes: Nothing beyond SystemVerilog
// Notes: Constants live in tx_pll_oc_defs.svh
package tx_pll_oc_pkg;
  typedef enum logic [1:0] {TOP_POR, TOP_OC, TOP_IDLE, TOP_IMG} top_state_t;
  typedef enum logic [2:0] {CH_IDLE, CH_ISOLATE, CH_CAL_BUF, CH_CAL_CDR, CH_RESTORE,
                            CH_DONE} chan_state_t;
endpackage

// [design/oc_channel.sv]
// Purpose: Offset cancellation sequencer for one receiver channel
// Assumes: cal_done_in comes from the analog side, asynchronous to clock_in
// Notes: A channel without a receiver reports done at once and drives nothing
`timescale 1ns/1ps
`default_nettype none
module oc_channel
  import tx_pll_oc_pkg::*;
#(
  parameter bit HAS_RX = 1'b1
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire logic cal_done_in,
  output logic rx_isolate_out,
  output logic cdr_div_force_out,
  output logic cal_buf_out,
  output logic cal_cdr_out,
  output logic done_out
);
  chan_state_t state_r, state_nxt;
  logic s1_r, s2_r, s3_r, filt_r, filt_nxt, filt_d_r;
  logic rise;

  // Change accepted only once stages two and three agree
  always_comb begin
    filt_nxt = (s2_r == s3_r) ? s3_r : filt_r;
  end

  assign rise = filt_r & ~filt_d_r;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      CH_IDLE: if (start_in) state_nxt = HAS_RX ? CH_ISOLATE : CH_DONE;
      CH_ISOLATE: state_nxt = CH_CAL_BUF;
      CH_CAL_BUF: if (rise) state_nxt = CH_CAL_CDR;
      CH_CAL_CDR: if (rise) state_nxt = CH_RESTORE;
      CH_RESTORE: state_nxt = CH_DONE;
      CH_DONE: state_nxt = CH_DONE;
      default: state_nxt = CH_IDLE;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_r <= CH_IDLE;
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      filt_r <= 1'b0;
      filt_d_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      s1_r <= cal_done_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      filt_r <= filt_nxt;
      filt_d_r <= filt_r;
    end
  end

  // Isolation and forced dividers span the whole calibration, released together
  assign rx_isolate_out = (state_r == CH_ISOLATE) || (state_r == CH_CAL_BUF) ||
                          (state_r == CH_CAL_CDR);
  assign cdr_div_force_out = rx_isolate_out;
  assign cal_buf_out = (state_r == CH_CAL_BUF);
  assign cal_cdr_out = (state_r == CH_CAL_CDR);
  assign done_out = (state_r == CH_DONE);
endmodule
`default_nettype wire

// [design/tx_pll_select_offset_cancel.sv]
// Purpose: Power-up offset cancellation of all receivers and image writes with TX PLL select
// Assumes: Image memory answers image_addr_out with image_data_in one cycle later
// Notes: Registers over Avalon-MM with waitrequest; one clock, synchronous reset
// Contract
// - Override input present: use it when enable high or enable absent.
// - Use image-stored index when enable present and low, or override absent.
// - Override selected: replace stored PLL index bit in written image words.
// - Override touches only the TX PLL index bit, no receiver settings.
// - Reference clock ids run 1 to 10, consistent across images.
// - After power-up, offset cancel every attached receiver before reconfiguration.
// - Cancellation starts by isolating receiver input pins from data path.
// - Force clock recovery onto fixed dividers during cancellation.
// - Step through states, calibrating input buffer then clock recovery.
// - Restore user divider settings after cancellation finishes.
// - Cancellation for receive-only and duplex channels, none for transmit-only.
// - Identical cancellation control for regular and PMA-only channels.
// - Busy low first cycle, high second cycle, falls at cancellation end.
// - Whole-image write request, 16-bit data in, 6-bit word address out.
//
// Added by the designer: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "tx_pll_oc_defs.svh"
module tx_pll_select_offset_cancel
  import tx_pll_oc_pkg::*;
#(
  parameter int NUM_CH = 4,
  parameter logic [NUM_CH-1:0] CH_HAS_RX = '1,
  parameter bit SEL_PRESENT = 1'b1,
  parameter bit SEL_EN_PRESENT = 1'b1
) (
  input wire logic clock_in,
  input wire logic rst_in,
  // Avalon-MM slave
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // User side
  input wire logic write_all_in,
  input wire logic pll_sel_in,
  input wire logic pll_sel_en_in,
  input wire logic [15:0] image_data_in,
  output logic [5:0] image_addr_out,
  output logic busy_out,
  output logic reconfig_done_out,
  output logic tx_pll_index_out,
  output logic [3:0] refclk_id_out,
  // Channel side
  input wire logic [NUM_CH-1:0] cal_done_in,
  output logic [NUM_CH-1:0] rx_isolate_out,
  output logic [NUM_CH-1:0] cdr_div_force_out,
  output logic [NUM_CH-1:0] cal_buf_out,
  output logic [NUM_CH-1:0] cal_cdr_out,
  output logic chan_wr_en_out,
  output logic [5:0] chan_wr_addr_out,
  output logic [15:0] chan_wr_data_out
);
  logic [NUM_CH-1:0] ch_done;
  logic oc_start;
  logic all_done;

  // Regular and PMA-only channels share the same sequencer
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    oc_channel #(
      .HAS_RX(CH_HAS_RX[i])
    ) u_ch (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .start_in(oc_start),
      .cal_done_in(cal_done_in[i]),
      .rx_isolate_out(rx_isolate_out[i]),
      .cdr_div_force_out(cdr_div_force_out[i]),
      .cal_buf_out(cal_buf_out[i]),
      .cal_cdr_out(cal_cdr_out[i]),
      .done_out(ch_done[i])
    );
  end

  // Channels without a receiver count as done at once
  assign all_done = &ch_done;

  // Bus slave: a request waits one cycle, then completes with registered data
  logic ack_r, ack_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [5:0] img_len_r, img_len_nxt;
  logic [3:0] refclk_id_r, refclk_id_nxt;
  logic refclk_err_r, refclk_err_nxt;
  logic go_r, go_nxt;
  logic bus_req, bus_wr;

  top_state_t state_r, state_nxt;
  logic [5:0] addr_r, addr_nxt;
  logic [5:0] len_r, len_nxt;
  logic issue_done_r, issue_done_nxt;
  logic wr_valid_r, wr_valid_nxt;
  logic [5:0] wr_addr_r, wr_addr_nxt;
  logic use_ovr_r, use_ovr_nxt;
  logic ovr_val_r, ovr_val_nxt;
  logic pll_idx_r, pll_idx_nxt;
  logic done_r, done_nxt;
  logic oc_done_r, oc_done_nxt;
  logic wen_r, wen_nxt;
  logic [5:0] waddr_r, waddr_nxt;
  logic [15:0] wdata_r, wdata_nxt;

  assign bus_req = avs_read_in | avs_write_in;
  assign bus_wr = avs_write_in & ack_r & avs_byteenable_in[0];
  assign avs_waitrequest_out = bus_req & ~ack_r;

  always_comb begin
    ack_nxt = bus_req & ~ack_r;
    rdata_nxt = rdata_r;
    img_len_nxt = img_len_r;
    refclk_id_nxt = refclk_id_r;
    refclk_err_nxt = refclk_err_r;
    go_nxt = 1'b0;
    if (avs_read_in && !ack_r) begin
      rdata_nxt = 32'h0000_0000;
      case (avs_address_in)
        `REG_IMG_LEN: rdata_nxt[5:0] = img_len_r;
        `REG_REFCLK_ID: rdata_nxt[3:0] = refclk_id_r;
        `REG_STATUS: begin
          // Snapshot taken in the request's first cycle
          rdata_nxt[`ST_BUSY_BIT] = busy_out;
          rdata_nxt[`ST_OC_DONE_BIT] = oc_done_r;
          rdata_nxt[`ST_IMG_BUSY_BIT] = (state_r == TOP_IMG);
          rdata_nxt[`ST_REFCLK_ERR_BIT] = refclk_err_r;
          rdata_nxt[`ST_PLL_IDX_BIT] = pll_idx_r;
          rdata_nxt[`ST_OVR_USED_BIT] = use_ovr_r;
        end
        `REG_OC_DONE: rdata_nxt[NUM_CH-1:0] = ch_done;
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
    if (bus_wr) begin
      case (avs_address_in)
        `REG_CTRL: begin
          go_nxt = avs_writedata_in[`CTRL_GO_BIT];
          if (avs_writedata_in[`CTRL_ERR_CLR_BIT]) refclk_err_nxt = 1'b0;
        end
        `REG_IMG_LEN: img_len_nxt = avs_writedata_in[5:0];
        `REG_REFCLK_ID: begin
          // Ids outside 1..10 are refused and flagged; set wins over a same-cycle clear
          if (avs_writedata_in[31:4] == 28'h0 &&
              avs_writedata_in[3:0] >= `REFCLK_ID_MIN &&
              avs_writedata_in[3:0] <= `REFCLK_ID_MAX) begin
            refclk_id_nxt = avs_writedata_in[3:0];
          end else begin
            refclk_err_nxt = 1'b1;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      img_len_r <= `IMG_LEN_RST;
      refclk_id_r <= `REFCLK_ID_RST;
      refclk_err_r <= 1'b0;
      go_r <= 1'b0;
    end else begin
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
      img_len_r <= img_len_nxt;
      refclk_id_r <= refclk_id_nxt;
      refclk_err_r <= refclk_err_nxt;
      go_r <= go_nxt;
    end
  end

  assign avs_readdata_out = rdata_r;
  // Exported id is the last accepted value since reset, or the reset value 1 until one is accepted
  assign refclk_id_out = refclk_id_r;

  // Top sequencer and image writer
  always_comb begin
    state_nxt = state_r;
    addr_nxt = addr_r;
    len_nxt = len_r;
    issue_done_nxt = issue_done_r;
    wr_valid_nxt = 1'b0;
    wr_addr_nxt = addr_r;
    use_ovr_nxt = use_ovr_r;
    ovr_val_nxt = ovr_val_r;
    pll_idx_nxt = pll_idx_r;
    done_nxt = 1'b0;
    oc_done_nxt = oc_done_r;
    wen_nxt = wr_valid_r;
    waddr_nxt = wr_addr_r;
    wdata_nxt = wdata_r;
    oc_start = 1'b0;
    // Word k arrives one cycle after its address; only the index bit may change
    if (wr_valid_r) begin
      wdata_nxt = image_data_in;
      if (wr_addr_r == `PLL_IDX_WORD) begin
        if (use_ovr_r) begin
          wdata_nxt[`PLL_IDX_BIT] = ovr_val_r;
          pll_idx_nxt = ovr_val_r;
        end else begin
          pll_idx_nxt = image_data_in[`PLL_IDX_BIT];
        end
      end
    end
    unique case (state_r)
      TOP_POR: begin
        // Busy stays low for this first cycle
        oc_start = 1'b1;
        state_nxt = TOP_OC;
      end
      TOP_OC: begin
        // User power-down held off throughout is assumed
        if (all_done) begin
          oc_done_nxt = 1'b1;
          state_nxt = TOP_IDLE;
        end
      end
      TOP_IDLE: begin
        // Image writes are only accepted once cancellation is over
        if ((write_all_in || go_r) && img_len_r != 6'h00) begin
          // Selection latched at start; inputs held steady by user
          use_ovr_nxt = SEL_PRESENT && (!SEL_EN_PRESENT || pll_sel_en_in);
          ovr_val_nxt = SEL_PRESENT ? pll_sel_in : 1'b0;
          addr_nxt = 6'h00;
          // Latched so a length write during the image cannot cut or stretch it
          len_nxt = img_len_r;
          issue_done_nxt = 1'b0;
          state_nxt = TOP_IMG;
        end
      end
      TOP_IMG: begin
        // Addresses issue back to back; two pipeline stages drain after the last
        if (!issue_done_r) begin
          wr_valid_nxt = 1'b1;
          if (addr_r == len_r - 6'h01) begin
            issue_done_nxt = 1'b1;
          end else begin
            addr_nxt = addr_r + 6'h01;
          end
        end else if (!wr_valid_r) begin
          done_nxt = 1'b1;
          state_nxt = TOP_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_r <= TOP_POR;
      addr_r <= 6'h00;
      len_r <= 6'h00;
      issue_done_r <= 1'b0;
      wr_valid_r <= 1'b0;
      wr_addr_r <= 6'h00;
      use_ovr_r <= 1'b0;
      ovr_val_r <= 1'b0;
      pll_idx_r <= 1'b0;
      done_r <= 1'b0;
      oc_done_r <= 1'b0;
      wen_r <= 1'b0;
      waddr_r <= 6'h00;
      wdata_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      addr_r <= addr_nxt;
      len_r <= len_nxt;
      issue_done_r <= issue_done_nxt;
      wr_valid_r <= wr_valid_nxt;
      wr_addr_r <= wr_addr_nxt;
      use_ovr_r <= use_ovr_nxt;
      ovr_val_r <= ovr_val_nxt;
      pll_idx_r <= pll_idx_nxt;
      done_r <= done_nxt;
      oc_done_r <= oc_done_nxt;
      wen_r <= wen_nxt;
      waddr_r <= waddr_nxt;
      wdata_r <= wdata_nxt;
    end
  end

  // One busy level covers cancellation and image writes
  assign busy_out = (state_r == TOP_OC) || (state_r == TOP_IMG);
  assign image_addr_out = addr_r;
  assign reconfig_done_out = done_r;
  // Index 0 selects block_pll_a, 1 selects block_pll_b
  assign tx_pll_index_out = pll_idx_r;
  // Registered so each merged word leaves together with its address
  assign chan_wr_en_out = wen_r;
  assign chan_wr_addr_out = waddr_r;
  assign chan_wr_data_out = wdata_r;
endmodule
`default_nettype wire

// [dv/oc_props_properties.sv]
// Purpose: Port-level properties of the PLL select / offset cancel block
// Assumes: Both override ports present; one clock domain
// Notes: Bound from the testbench top file
`timescale 1ns/1ps
`default_nettype none
`include "tx_pll_oc_defs.svh"
module oc_props #(
  parameter int NUM_CH = 4
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic pll_sel_in,
  input wire logic pll_sel_en_in,
  input wire logic busy_out,
  input wire logic reconfig_done_out,
  input wire logic tx_pll_index_out,
  input wire logic [NUM_CH-1:0] rx_isolate_out,
  input wire logic [NUM_CH-1:0] cdr_div_force_out,
  input wire logic [NUM_CH-1:0] cal_buf_out,
  input wire logic [NUM_CH-1:0] cal_cdr_out,
  input wire logic chan_wr_en_out,
  input wire logic [5:0] chan_wr_addr_out,
  input wire logic [15:0] chan_wr_data_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  sequence s_por;
    !busy_out ##1 busy_out;
  endsequence
  sequence s_done;
    !busy_out ##1 !reconfig_done_out;
  endsequence
  property p_por; $fell(rst_in) |-> s_por; endproperty
  property p_force; rx_isolate_out == cdr_div_force_out; endproperty
  property p_cal_iso; ((cal_buf_out | cal_cdr_out) & ~rx_isolate_out) == '0; endproperty
  property p_one_step; (cal_buf_out & cal_cdr_out) == '0; endproperty
  property p_busy_fall;
    $fell(busy_out) |-> rx_isolate_out == '0 && $past(rx_isolate_out) == '0;
  endproperty
  property p_oc_busy; |rx_isolate_out |-> busy_out; endproperty
  property p_done; reconfig_done_out |-> $past(chan_wr_en_out) ##0 s_done; endproperty
  property p_idx_word;
    chan_wr_en_out && chan_wr_addr_out == `PLL_IDX_WORD && pll_sel_en_in
      |-> chan_wr_data_out[`PLL_IDX_BIT] == pll_sel_in;
  endproperty
  property p_addr_step;
    chan_wr_en_out && $past(chan_wr_en_out) |-> chan_wr_addr_out == $past(chan_wr_addr_out) + 6'h01;
  endproperty
  property p_tx_idx; reconfig_done_out && pll_sel_en_in |-> tx_pll_index_out == pll_sel_in; endproperty
  a_por: assert property (p_por) else $error("busy start");
  a_force: assert property (p_force) else $error("divider force");
  a_cal_iso: assert property (p_cal_iso) else $error("cal not isolated");
  a_one_step: assert property (p_one_step) else $error("two steps");
  a_busy_fall: assert property (p_busy_fall) else $error("busy early");
  a_oc_busy: assert property (p_oc_busy) else $error("isolate idle");
  a_done: assert property (p_done) else $error("done pulse");
  a_idx_word: assert property (p_idx_word) else $error("index bit");
  a_addr_step: assert property (p_addr_step) else $error("addr step");
  a_tx_idx: assert property (p_tx_idx) else $error("tx index");
endmodule
`default_nettype wire

// [dv/chan_model.sv]
// Purpose: Receiver channels answering calibration steps
// Assumes: One done line per channel
// Notes: Done stays high into the next step and drops when the count wraps, so every rise is fresh
`timescale 1ns/1ps
`default_nettype none
module chan_model #(
  parameter int NUM_CH = 4
) (
  input wire logic clock_in,
  input wire logic [NUM_CH-1:0] cal_buf_in,
  input wire logic [NUM_CH-1:0] cal_cdr_in,
  input wire logic [NUM_CH-1:0] slow_in,
  output logic [NUM_CH-1:0] cal_done_out
);
  int cnt[NUM_CH] = '{default: 0};
  always @(posedge clock_in) begin
    for (int i = 0; i < NUM_CH; i++) begin
      if (cnt[i] == (slow_in[i] ? 27 : 9))
        cnt[i] <= 0;
      else if (cnt[i] != 0 || cal_buf_in[i] || cal_cdr_in[i])
        cnt[i] <= cnt[i] + 1;
      cal_done_out[i] <= cnt[i] >= (slow_in[i] ? 20 : 2);
    end
  end
endmodule
`default_nettype wire

// [dv/testbench.sv]
// Purpose: Self-checking bench for the PLL select / offset cancel block
// Assumes: Image memory answers one cycle after the address
// Notes: Channel 2 has no receiver
`timescale 1ns/1ps
`default_nettype none
`include "tx_pll_oc_defs.svh"
module testbench;
  localparam int NUM_CH = 4;
  localparam logic [NUM_CH-1:0] HAS_RX = 4'hb;
  logic clock_in = 0, rst_in = 1, avs_read_in = 0, avs_write_in = 0, write_all_in = 0;
  logic pll_sel_in = 0, pll_sel_en_in = 0, sel, ovr;
  logic [7:0] avs_address_in = '0;
  logic [31:0] avs_writedata_in = '0, avs_readdata_out, q;
  logic [15:0] image_data_in = '0, chan_wr_data_out, base = '0, w2;
  logic avs_waitrequest_out, busy_out, reconfig_done_out, tx_pll_index_out, chan_wr_en_out;
  logic [5:0] image_addr_out, chan_wr_addr_out;
  logic [3:0] refclk_id_out;
  logic [NUM_CH-1:0] cal_done_in, rx_isolate_out, cdr_div_force_out, cal_buf_out, cal_cdr_out;
  logic [NUM_CH-1:0] slow, seen_buf = '0, seen_cdr = '0;
  int seed = 32'hce622829, mismatches = 0, n_checks = 0, words = 0, len, n;
  tx_pll_select_offset_cancel #(.NUM_CH(NUM_CH), .CH_HAS_RX(HAS_RX)) uut (
    .clock_in(clock_in), .rst_in(rst_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(4'hf),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .write_all_in(write_all_in), .pll_sel_in(pll_sel_in), .pll_sel_en_in(pll_sel_en_in),
    .image_data_in(image_data_in), .image_addr_out(image_addr_out), .busy_out(busy_out),
    .reconfig_done_out(reconfig_done_out), .tx_pll_index_out(tx_pll_index_out),
    .refclk_id_out(refclk_id_out), .cal_done_in(cal_done_in),
    .rx_isolate_out(rx_isolate_out), .cdr_div_force_out(cdr_div_force_out),
    .cal_buf_out(cal_buf_out), .cal_cdr_out(cal_cdr_out),
    .chan_wr_en_out(chan_wr_en_out), .chan_wr_addr_out(chan_wr_addr_out),
    .chan_wr_data_out(chan_wr_data_out));
  chan_model #(.NUM_CH(NUM_CH)) peer (.clock_in(clock_in), .cal_buf_in(cal_buf_out),
    .cal_cdr_in(cal_cdr_out), .slow_in(slow), .cal_done_out(cal_done_in));
  initial forever #5 clock_in = ~clock_in;
  function automatic logic [15:0] img(input logic [5:0] a);
    return base ^ {a, a, a[3:0]};
  endfunction
  function automatic logic [15:0] exp_word(input logic [5:0] a);
    logic [15:0] w;
    w = img(a);
    if (a == `PLL_IDX_WORD && ovr)
      w[`PLL_IDX_BIT] = sel;
    return w;
  endfunction
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    logic w;
    @(posedge clock_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    for (int i = 0; i < 50; i++) begin
      // Inputs only move at rising edges, so this is the value the next edge sees
      @(negedge clock_in);
      w = avs_waitrequest_out;
      @(posedge clock_in);
      if (w === 1'b0)
        break;
    end
    if (w !== 1'b0) begin
      mismatches++;
      end_of_test();
    end
    q = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask
  task automatic reset_oc();
    rst_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    for (n = 0; busy_out !== 1'b0 && n < 3000; n++) @(posedge clock_in);
    chk("oc_end", n < 3000, 1);
    if (n >= 3000)
      end_of_test();
    chk("isolate", rx_isolate_out, 0);
    chk("force", cdr_div_force_out, 0);
    bus(0, `REG_STATUS, 0);
    chk("oc_done", q[`ST_OC_DONE_BIT], 1);
    bus(0, `REG_OC_DONE, 0);
    chk("ch_done", q, 32'((1 << NUM_CH) - 1));
  endtask
  always @(posedge clock_in) begin
    image_data_in <= img(image_addr_out);
    seen_buf <= seen_buf | cal_buf_out;
    seen_cdr <= seen_cdr | cal_cdr_out;
    if (chan_wr_en_out === 1'b1) begin
      words++;
      chk("wr_addr", chan_wr_addr_out, words - 1);
      chk("wr_data", chan_wr_data_out, exp_word(chan_wr_addr_out));
    end
  end
  initial begin
    repeat (20000) @(posedge clock_in);
    mismatches++;
    end_of_test();
  end
  initial begin
    slow = NUM_CH'($random(seed));
    reset_oc();
    chk("seen_buf", seen_buf, HAS_RX);
    chk("seen_cdr", seen_cdr, HAS_RX);
    bus(0, 8'h40, 0);
    chk("unmapped", q, 0);
    bus(0, `REG_IMG_LEN, 0);
    chk("img_len", q, `IMG_LEN_RST);
    bus(1, `REG_REFCLK_ID, 32'hb);
    bus(0, `REG_REFCLK_ID, 0);
    chk("id_keep", q, `REFCLK_ID_RST);
    bus(0, `REG_STATUS, 0);
    chk("id_err", q[`ST_REFCLK_ERR_BIT], 1);
    bus(1, `REG_CTRL, 32'h1 << `CTRL_ERR_CLR_BIT);
    bus(0, `REG_STATUS, 0);
    chk("id_clr", q[`ST_REFCLK_ERR_BIT], 0);
    bus(1, `REG_REFCLK_ID, `REFCLK_ID_MAX);
    bus(0, `REG_REFCLK_ID, 0);
    chk("id", q, `REFCLK_ID_MAX);
    chk("id_out", refclk_id_out, `REFCLK_ID_MAX);
    for (int k = 0; k < 8; k++) begin
      base = 16'($random(seed));
      len = k == 7 ? 59 : 3 + $unsigned($random(seed)) % 6;
      {ovr, sel} = k < 4 ? 2'(k) : 2'($random(seed));
      pll_sel_in <= sel;
      pll_sel_en_in <= ovr;
      bus(1, `REG_IMG_LEN, len);
      words = 0;
      if (k[0]) begin
        bus(1, `REG_CTRL, 32'h1 << `CTRL_GO_BIT);
      end else begin
        write_all_in <= 1'b1;
        @(posedge clock_in);
        write_all_in <= 1'b0;
      end
      for (n = 0; reconfig_done_out !== 1'b1 && n < 200; n++) @(posedge clock_in);
      @(posedge clock_in);
      w2 = img(`PLL_IDX_WORD);
      chk("done", n < 200, 1);
      if (n >= 200)
        end_of_test();
      chk("words", words, len);
      chk("tx_idx", tx_pll_index_out, ovr ? sel : w2[`PLL_IDX_BIT]);
      bus(0, `REG_STATUS, 0);
      chk("st_idx", q[`ST_PLL_IDX_BIT], ovr ? sel : w2[`PLL_IDX_BIT]);
      chk("st_ovr", q[`ST_OVR_USED_BIT], ovr);
    end
    // Second reset mid-run: cancellation must run again and the reference clock id returns to its reset value
    slow <= NUM_CH'($random(seed));
    reset_oc();
    bus(0, `REG_REFCLK_ID, 0);
    chk("id_rst", q, `REFCLK_ID_RST);
    chk("id_out_rst", refclk_id_out, `REFCLK_ID_RST);
    end_of_test();
  end
endmodule
bind tx_pll_select_offset_cancel oc_props #(.NUM_CH(NUM_CH)) u_props (
  .clock_in(clock_in), .rst_in(rst_in), .pll_sel_in(pll_sel_in),
  .pll_sel_en_in(pll_sel_en_in), .busy_out(busy_out), .reconfig_done_out(reconfig_done_out),
  .tx_pll_index_out(tx_pll_index_out), .rx_isolate_out(rx_isolate_out),
  .cdr_div_force_out(cdr_div_force_out), .cal_buf_out(cal_buf_out),
  .cal_cdr_out(cal_cdr_out), .chan_wr_en_out(chan_wr_en_out),
  .chan_wr_addr_out(chan_wr_addr_out), .chan_wr_data_out(chan_wr_data_out));
`default_nettype wire
